// ==== design/samd_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none

// Operation
// R01 - Top three address bits pick one of eight 512MB segments.
// R02 - External, internal SRAM, coupled SRAM segments fixed regardless of view.
// R03 - Memory view select resets to 0x0.
// R04 - View 0 aliases external memory into the low segment.
// R05 - View 1 maps coupled SRAM into the low segment.
// R06 - Low coupled SRAM alias ends at 0x00003FFF.
// R07 - View 2 maps internal SRAM low, processor only.
// R08 - View 3 is reserved; low segment accesses abort.
// R09 - Coupled SRAM serves only the processor; others get bus error.
// R10 - Internal SRAM serves processor, DMA and panel controller.
// R11 - Coupled SRAM answers processor with zero wait states.
// R12 - External segment has eight 64MB sections; first four are chip selects.
// R13 - Upper four external sections start no cycle and do not abort.
// R14 - Peripheral segment decodes in 4KB windows, 21 for peripherals; the decoder maps only 18 of them (indices 0-17).
// R15 - AHB map: APB bridge, memory controller, panel controller, interrupt controller.
// R16 - APB windows follow the printed peripheral order.
// R17 - Software loads panel frame bases with reachable addresses first.
// R18 - Memory port: 24-bit address, 16-bit data, four chip selects.
// R19 - Signals named with leading n are active low.
// R20 - Bits 27:26 pick chip select; bits 23:0 form bank address.
// R21 - Reserved and unassigned targets end with an error response.
module samd_decoder (
    input wire logic core_clk,
    input wire logic rstn,
    input wire samd_pkg::samd_req_t req,
    input wire logic view_wr,
    input wire logic [1:0] view_wdata,
    output logic [1:0] memory_view_select,
    output samd_pkg::samd_dec_t dec
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] view;
        samd_pkg::samd_dec_t dec;
    } samd_state_t;

    samd_state_t state_reg;
    samd_state_t state_next;

    // Maps a 4KB APB window number to its peripheral index, or 31 if none.
    function automatic logic [4:0] samd_apb_index(input logic [19:0] win);
        logic [19:0] off;
        off = win - samd_pkg::WIN_APB_BASE;
        // R16 - printed peripheral order
        if (off <= 20'h00006) begin
            samd_apb_index = off[4:0];
        end else if (off >= 20'h0001B && off <= 20'h00025) begin
            samd_apb_index = 5'(off[4:0] - 5'h14);
        end else begin
            samd_apb_index = 5'h1F;
        end
    endfunction

    // Decodes a memory-type target for the requesting master.
    function automatic samd_pkg::samd_resp_t samd_mem_resp(
        input samd_pkg::samd_target_t t,
        input samd_pkg::samd_master_t m
    );
        samd_mem_resp = samd_pkg::SAMD_R_OK;
        // R09 - processor-only coupled SRAM
        if (t == samd_pkg::SAMD_T_TCSRAM && m != samd_pkg::SAMD_M_CPU) begin
            samd_mem_resp = samd_pkg::SAMD_R_BUSERR;
        end
    endfunction

    // ----------------------------------------------------------------
    // Next-state decode
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] seg;
        logic [4:0] idx;
        seg = req.addr[31:29];
        idx = 5'h1F;
        state_next = state_reg;
        state_next.dec = '0;
        state_next.dec.cs_n = 4'hF;
        state_next.dec.apb_sel = 5'h1F;
        state_next.dec.valid = req.valid;
        state_next.dec.target = samd_pkg::SAMD_T_NONE;
        state_next.dec.resp = samd_pkg::SAMD_R_OK;
        // Software writes the view; the decode below uses the held value.
        if (view_wr) begin
            state_next.view = view_wdata;
        end
        // R01 - segment from top bits
        case (seg)
            // R02 - fixed segments
            samd_pkg::SEG_EXT: begin
                state_next.dec.target = samd_pkg::SAMD_T_EXTMEM;
            end
            samd_pkg::SEG_ISRAM: begin
                // R10 - shared internal SRAM
                state_next.dec.target = samd_pkg::SAMD_T_ISRAM;
            end
            samd_pkg::SEG_TCSRAM: begin
                state_next.dec.target = samd_pkg::SAMD_T_TCSRAM;
            end
            samd_pkg::SEG_LOW: begin
                case (state_reg.view)
                    // R04 - external alias
                    samd_pkg::VIEW_EXT: begin
                        state_next.dec.target = samd_pkg::SAMD_T_EXTMEM;
                    end
                    // R05 - coupled SRAM low
                    samd_pkg::VIEW_TCSRAM: begin
                        // R06 - alias upper bound
                        if (req.addr <= samd_pkg::TCSRAM_LOW_LAST) begin
                            state_next.dec.target = samd_pkg::SAMD_T_TCSRAM;
                        end else begin
                            state_next.dec.resp = samd_pkg::SAMD_R_BUSERR;
                        end
                    end
                    // R07 - internal SRAM low
                    samd_pkg::VIEW_ISRAM: begin
                        if (req.master == samd_pkg::SAMD_M_CPU) begin
                            state_next.dec.target = samd_pkg::SAMD_T_ISRAM;
                        end else begin
                            state_next.dec.resp = samd_pkg::SAMD_R_BUSERR;
                        end
                    end
                    // R08 - reserved view aborts
                    default: begin
                        state_next.dec.resp = samd_pkg::SAMD_R_ABORT;
                    end
                endcase
            end
            samd_pkg::SEG_PERIPH: begin
                // R14 - 4KB window decode
                // R15 - primary AHB map
                if (req.addr >= samd_pkg::APB_FIRST && req.addr <= samd_pkg::APB_LAST) begin
                    idx = samd_apb_index(req.addr[31:12]);
                    if (idx != 5'h1F) begin
                        state_next.dec.target = samd_pkg::SAMD_T_APB;
                        state_next.dec.apb_sel = idx;
                    end else begin
                        state_next.dec.resp = samd_pkg::SAMD_R_BUSERR;
                    end
                end else if (req.addr[31:12] == samd_pkg::WIN_SMC) begin
                    state_next.dec.target = samd_pkg::SAMD_T_SMC_REG;
                end else if (req.addr[31:12] == samd_pkg::WIN_LCD) begin
                    state_next.dec.target = samd_pkg::SAMD_T_LCD_REG;
                end else if (req.addr[31:12] == samd_pkg::WIN_IRQ) begin
                    state_next.dec.target = samd_pkg::SAMD_T_IRQ_REG;
                end else begin
                    state_next.dec.resp = samd_pkg::SAMD_R_BUSERR;
                end
            end
            // R21 - reserved segments error out
            default: begin
                state_next.dec.resp = samd_pkg::SAMD_R_BUSERR;
            end
        endcase
        state_next.dec.resp = (state_next.dec.resp == samd_pkg::SAMD_R_OK)
            ? samd_mem_resp(state_next.dec.target, req.master) : state_next.dec.resp;
        if (state_next.dec.resp != samd_pkg::SAMD_R_OK) begin
            state_next.dec.target = samd_pkg::SAMD_T_NONE;
        end
        // R11 - zero wait coupled SRAM
        state_next.dec.zero_wait = (state_next.dec.target == samd_pkg::SAMD_T_TCSRAM);
        if (state_next.dec.target == samd_pkg::SAMD_T_EXTMEM) begin
            // R13 - upper sections are null
            if (req.addr[samd_pkg::SECT_HI_BIT]) begin
                state_next.dec.target = samd_pkg::SAMD_T_NULL;
            end else begin
                // R12 - chip select sections
                // R20 - select bits and bank address
                // R19 - active low selects
                state_next.dec.cs_n = ~(4'h1 << req.addr[samd_pkg::CS_HI:samd_pkg::CS_LO]);
                // R18 - 24-bit bank address
                state_next.dec.bank_addr = req.addr[samd_pkg::BANK_ADDR_W-1:0];
            end
        end
        if (!req.valid) begin
            state_next.dec = '0;
            state_next.dec.cs_n = 4'hF;
            state_next.dec.apb_sel = 5'h1F;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            // R03 - view resets to zero
            state_reg.view <= samd_pkg::VIEW_RESET;
            state_reg.dec <= '0;
            state_reg.dec.cs_n <= 4'hF;
            state_reg.dec.apb_sel <= 5'h1F;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state register.
    assign memory_view_select = state_reg.view;
    assign dec = state_reg.dec;

endmodule : samd_decoder

`default_nettype wire

// ==== design/samd_pkg.sv ====
package samd_pkg;

    // ----------------------------------------------------------------
    // Segment and view encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] SEG_LOW = 3'h0;
    localparam logic [2:0] SEG_EXT = 3'h2;
    localparam logic [2:0] SEG_ISRAM = 3'h3;
    localparam logic [2:0] SEG_TCSRAM = 3'h4;
    localparam logic [2:0] SEG_PERIPH = 3'h7;
    localparam logic [1:0] VIEW_EXT = 2'h0;
    localparam logic [1:0] VIEW_TCSRAM = 2'h1;
    localparam logic [1:0] VIEW_ISRAM = 2'h2;
    localparam logic [1:0] VIEW_RESET = 2'h0;
    localparam logic [31:0] TCSRAM_LOW_LAST = 32'h0000_3FFF;
    localparam logic [31:0] APB_FIRST = 32'hFFFC_0000;
    localparam logic [31:0] APB_LAST = 32'hFFFE_FFFF;
    localparam logic [19:0] WIN_SMC = 20'hFFFF1;
    localparam logic [19:0] WIN_LCD = 20'hFFFF4;
    localparam logic [19:0] WIN_IRQ = 20'hFFFFF;
    localparam logic [19:0] WIN_APB_BASE = 20'hFFFC0;
    localparam int CS_HI = 27;
    localparam int CS_LO = 26;
    localparam int SECT_HI_BIT = 28;
    localparam int BANK_ADDR_W = 24;
    localparam int APB_WIN_N = 21;

    // ----------------------------------------------------------------
    // Masters, targets and result
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SAMD_M_CPU = 2'h0,
        SAMD_M_DMA = 2'h1,
        SAMD_M_LCD = 2'h2
    } samd_master_t;

    typedef enum logic [3:0] {
        SAMD_T_NONE = 4'h0,
        SAMD_T_EXTMEM = 4'h1,
        SAMD_T_ISRAM = 4'h2,
        SAMD_T_TCSRAM = 4'h3,
        SAMD_T_SMC_REG = 4'h4,
        SAMD_T_LCD_REG = 4'h5,
        SAMD_T_IRQ_REG = 4'h6,
        SAMD_T_APB = 4'h7,
        SAMD_T_NULL = 4'h8
    } samd_target_t;

    typedef enum logic [1:0] {
        SAMD_R_OK = 2'h0,
        SAMD_R_BUSERR = 2'h1,
        SAMD_R_ABORT = 2'h2
    } samd_resp_t;

    typedef struct packed {
        logic valid;
        samd_master_t master;
        logic [31:0] addr;
    } samd_req_t;

    typedef struct packed {
        logic valid;
        samd_target_t target;
        samd_resp_t resp;
        logic [3:0] cs_n;
        logic [23:0] bank_addr;
        logic [4:0] apb_sel;
        logic zero_wait;
    } samd_dec_t;

endpackage : samd_pkg

// ==== dv/samd_bus_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bus master model
// ----------------------------------------
module samd_bus_master (
    input wire logic core_clk,
    output var samd_pkg::samd_req_t req
);
    initial req = '0;
    // frame addresses, reachable or not
    // The panel master is also given addresses it cannot reach, which end in bus error.
    // Presents one request from a falling edge until the rising edge takes it.
    task automatic xfer(input samd_pkg::samd_master_t m, input logic [31:0] a);
        @(negedge core_clk);
        req = '{1'b1, m, a};
        @(posedge core_clk);
    endtask
    // Idle drops valid and inverts the address once per call, so a stale value never looks valid.
    task automatic idle();
        @(negedge core_clk);
        req = '{1'b0, req.master, ~req.addr};
    endtask
endmodule // samd_bus_master
`default_nettype wire

// ==== dv/samd_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Decoder port checks
// ----------------------------------------
module samd_chk (
    input wire logic core_clk,
    input wire logic rstn,
    input wire samd_pkg::samd_req_t req,
    input wire logic view_wr,
    input wire logic [1:0] view_wdata,
    input wire logic [1:0] memory_view_select,
    input wire samd_pkg::samd_dec_t dec
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Segment of the request in flight.
    wire logic [2:0] seg = req.addr[31:29];
    sequence s_seg(logic [2:0] s);
        req.valid && seg == s;
    endsequence
    sequence s_low(logic [1:0] v);
        s_seg(3'h0) ##0 memory_view_select == v;
    endsequence
    a_view_reset: assert property ($rose(rstn) |-> memory_view_select == 2'h0)
        else $error("view not cleared by reset");
    a_view_write: assert property (view_wr |=> memory_view_select == $past(view_wdata))
        else $error("view write lost");
    a_answer_next: assert property (req.valid |=> dec.valid)
        else $error("no answer one cycle later");
    a_ext_select: assert property (s_seg(3'h2) ##0 !req.addr[28] |=>
        dec.cs_n == ~(4'h1 << $past(req.addr[27:26])) &&
        dec.bank_addr == $past(req.addr[23:0]))
        else $error("wrong chip select or bank address");
    a_ext_upper: assert property (s_seg(3'h2) ##0 req.addr[28] |=>
        dec.cs_n == 4'hF && dec.resp == samd_pkg::SAMD_R_OK)
        else $error("upper section started a cycle");
    a_tcsram_guard: assert property (s_seg(3'h4) |=>
        dec.zero_wait == ($past(req.master) == samd_pkg::SAMD_M_CPU) &&
        (dec.resp == samd_pkg::SAMD_R_OK) == dec.zero_wait)
        else $error("coupled SRAM access rule broken");
    a_low_abort: assert property (s_low(2'h3) |=> dec.resp == samd_pkg::SAMD_R_ABORT)
        else $error("reserved view did not abort");
    a_low_limit: assert property (s_low(2'h1) ##0 req.addr > 32'h0000_3FFF |=>
        dec.resp == samd_pkg::SAMD_R_BUSERR)
        else $error("coupled SRAM alias too large");
    a_reserved_err: assert property (req.valid && seg inside {3'h1, 3'h5, 3'h6} |=>
        dec.resp == samd_pkg::SAMD_R_BUSERR && dec.target == samd_pkg::SAMD_T_NONE)
        else $error("reserved segment not refused");
    a_irq_window: assert property (req.valid && req.addr[31:12] == 20'hFFFFF |=>
        dec.target == samd_pkg::SAMD_T_IRQ_REG)
        else $error("interrupt window misrouted");
endmodule // samd_chk
bind samd_decoder samd_chk u_chk (.core_clk(core_clk), .rstn(rstn), .req(req),
    .view_wr(view_wr), .view_wdata(view_wdata), .memory_view_select(memory_view_select),
    .dec(dec));
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Decoder testbench
// ----------------------------------------
module testbench;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic view_wr = 1'b0;
    logic [1:0] view_wdata = 2'h0;
    wire logic [1:0] memory_view_select;
    wire samd_pkg::samd_req_t req;
    wire samd_pkg::samd_dec_t dec;
    int n_mismatch = 0;
    int comparisons = 0;
    // A 200 MHz clock.
    always #2.5 core_clk = ~core_clk;
    samd_bus_master mst (.core_clk(core_clk), .req(req));
    samd_decoder uut (.core_clk(core_clk), .rstn(rstn), .req(req), .view_wr(view_wr),
        .view_wdata(view_wdata), .memory_view_select(memory_view_select), .dec(dec));
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Targets: 0 none, 1 ext, 2 sram, 3 coupled, 4-6 registers, 7 APB, 8 null; resp 1 error, 2 abort.
    task automatic send(input logic [1:0] m, input logic [31:0] a, input logic [3:0] t,
        input logic [1:0] r);
        mst.xfer(samd_pkg::samd_master_t'(m), a);
        #1;
        cmp(dec.target, t);
        cmp(dec.resp, r);
    endtask
    task automatic set_view(input logic [1:0] v);
        mst.idle();
        view_wr = 1'b1;
        view_wdata = v;
        @(negedge core_clk);
        view_wr = 1'b0;
        cmp(memory_view_select, v);
    endtask
    task automatic s_reset();
        @(negedge core_clk);
        rstn = 1'b0;
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
        cmp(memory_view_select, 2'h0);
        cmp({dec.valid, dec.cs_n, dec.apb_sel}, 10'h1FF);
    endtask
    task automatic s_ext();
        send(2'h0, 32'h0C00_0020, 4'h1, 2'h0);
        cmp({dec.cs_n, dec.bank_addr}, 28'h700_0020);
        send(2'h1, 32'h48AB_CDEF, 4'h1, 2'h0);
        cmp({dec.cs_n, dec.bank_addr}, 28'hBAB_CDEF);
        send(2'h0, 32'h5C00_0000, 4'h8, 2'h0);
        cmp(dec.cs_n, 4'hF);
    endtask
    task automatic s_fixed();
        for (int v = 0; v < 3; v++) begin
            set_view(v[1:0]);
            send(2'h1, 32'h6000_0010, 4'h2, 2'h0);
            send(2'h0, 32'h8000_0000, 4'h3, 2'h0);
            cmp(dec.zero_wait, 1'b1);
            send(2'h2, 32'h8000_0004, 4'h0, 2'h1);
        end
    endtask
    task automatic s_low();
        set_view(2'h1);
        send(2'h0, 32'h0000_3FFC, 4'h3, 2'h0);
        send(2'h0, 32'h0000_4000, 4'h0, 2'h1);
        set_view(2'h2);
        send(2'h0, 32'h0000_0100, 4'h2, 2'h0);
        send(2'h2, 32'h0000_0100, 4'h0, 2'h1);
        set_view(2'h3);
        send(2'h0, 32'h0000_0000, 4'h0, 2'h2);
    endtask
    task automatic p(input logic [31:0] a, input logic [3:0] t, input logic [4:0] sel);
        send(2'h0, a, t, {1'b0, t == 4'h0});
        cmp(dec.apb_sel, sel);
    endtask
    task automatic s_periph();
        p(32'hFFFC_0000, 4'h7, 5'd0);
        p(32'hFFFC_6FFC, 4'h7, 5'd6);
        p(32'hFFFD_B000, 4'h7, 5'd7);
        p(32'hFFFE_5000, 4'h7, 5'd17);
        p(32'hFFFC_7000, 4'h0, 5'h1F);
        p(32'hFFFF_1000, 4'h4, 5'h1F);
        p(32'hFFFF_4000, 4'h5, 5'h1F);
        p(32'hFFFF_F000, 4'h6, 5'h1F);
        p(32'hFFFF_2000, 4'h0, 5'h1F);
        p(32'hA000_0000, 4'h0, 5'h1F);
    endtask
    // Cuts a hang short.
    initial begin
        #20000;
        n_mismatch++;
        final_report();
    end
    // Main sequence, with a second reset after a view change.
    initial begin
        s_reset();
        s_ext();
        s_fixed();
        s_low();
        s_periph();
        s_reset();
        s_ext();
        mst.idle();
        final_report();
    end
endmodule // testbench
`default_nettype wire
